/* logic/event_trigger_break_sequencer.sv */
/*
  Mode sequencer linking two event channels: arm, window-limit and
  independent relations, break modes, general purpose counter, halt request.
  Assumes comparator results and bus captures arrive synchronous to pclk;
  a software APB master sets modes and issues run commands.
*/
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - Arm: channel triggers alternately enable each other
// - Go with address clears, enables counter outside arm relations
// - Program end disables counter in event modes
// - Event modes never freeze or break
// - Arm, independent: both triggers driven out
// - Window: both channels' compares in one transaction
// - Window: ignore second data and probe
// - Window match feeds first-channel counters
// - Independent: each channel fires alone
// - Clear, restart, command revert to independent
// - Break-first halts on first trigger
// - Break-second halts on second trigger
// - Break-arm alternates, halts on second
// - Break-limit uses window match, halts first
// - Break-independent halts on either trigger
// - Freeze mode: first freezes, second halts
// - Break trigger freezes buffer, halts with step option
// - After break: step stops, continue resumes
// - Break captures address, data, registers
// - Default return option is step
// - Counter saturates at its maximum
// - Arm: counter runs first to second trigger
module event_trigger_break_sequencer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_addr_match,
  input  wire logic        first_data_match,
  input  wire logic        first_probe_match,
  input  wire logic        first_cycle_match,
  input  wire logic        second_addr_match,
  input  wire logic        second_data_match,
  input  wire logic        second_probe_match,
  input  wire logic        second_cycle_match,
  input  wire logic        bus_valid,
  input  wire logic [15:0] bus_addr,
  input  wire logic [15:0] bus_data,
  input  wire logic [31:0] cpu_regs,
  input  wire logic        unit_tick,
  input  wire logic        halt_insn,
  input  wire logic        halt_ack,
  input  wire logic [15:0] first_pass_count,
  input  wire logic [15:0] first_delay_count,
  input  wire logic [15:0] second_pass_count,
  input  wire logic [15:0] second_delay_count,
  output logic             first_trig_out,
  output logic             second_trig_out,
  output logic             trace_freeze,
  output logic             halt_request,
  output logic             run_enable
);

  typedef struct packed {
    sequencer_pkg::event_mode_t evt_mode;
    sequencer_pkg::break_mode_t brk_mode;
    logic                       cont;
    logic                       second_armed;
    logic                       running;
    logic                       cnt_en;
    logic [15:0]                count;
    logic                       frozen;
    logic                       halt;
    logic                       trig1;
    logic                       trig2;
    logic [15:0]                cap_addr;
    logic [15:0]                cap_data;
    logic [31:0]                cap_regs;
    logic [31:0]                last_bus;
    logic [31:0]                last_regs;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       err;
  } seq_state_t;

  seq_state_t  state;
  seq_state_t  next_state;
  logic        match1;
  logic        match2;
  logic        raw_trig1;
  logic        raw_trig2;
  logic        arm_like;
  logic        window;
  logic        bus_wr;
  logic        bus_rd;
  logic        cmd_wr;
  logic        cmd_go_addr;
  logic        cmd_go_resume;
  logic        cmd_escape;
  logic        cmd_sw_break;
  logic        cmd_ack;
  logic        cmd_ind;
  logic        brk_fire;
  logic        frz_fire;
  logic        cnt_start;
  logic        cnt_stop;
  logic        prog_end;

  // Relation decode from the encoded modes
  always_comb begin
    arm_like = (state.brk_mode == sequencer_pkg::BRK_ARM)
            || (state.brk_mode == sequencer_pkg::BRK_FREEZE)
            || (state.brk_mode == sequencer_pkg::BRK_NONE
                && state.evt_mode == sequencer_pkg::EVM_ARM);
    window   = (state.brk_mode == sequencer_pkg::BRK_LIMIT)
            || (state.brk_mode == sequencer_pkg::BRK_NONE
                && state.evt_mode == sequencer_pkg::EVM_WINDOW_LIMIT);
  end

  // Channel match gating per relation
  always_comb begin
    match1 = bus_valid && first_addr_match && first_data_match
          && first_probe_match && first_cycle_match;
    match2 = bus_valid && second_addr_match && second_data_match
          && second_probe_match && second_cycle_match;
    if (window) begin
      match1 = match1 && second_addr_match && second_cycle_match;
    end
    if (arm_like) begin
      match1 = match1 && !state.second_armed;
      match2 = match2 && state.second_armed;
    end
    if (state.brk_mode == sequencer_pkg::BRK_FIRST) begin
      match2 = 1'b0;
    end
    if (state.brk_mode == sequencer_pkg::BRK_SECOND) begin
      match1 = 1'b0;
    end
  end

  // Pass and delay counting per channel, no cross-coupling otherwise
  trigger_channel first_channel (
    .pclk        (pclk),
    .presetn     (presetn),
    .match       (match1),
    .unit_tick   (unit_tick),
    .pass_count  (first_pass_count),
    .delay_count (first_delay_count),
    .trigger     (raw_trig1)
  );

  trigger_channel second_channel (
    .pclk        (pclk),
    .presetn     (presetn),
    .match       (match2),
    .unit_tick   (unit_tick),
    .pass_count  (second_pass_count),
    .delay_count (second_delay_count),
    .trigger     (raw_trig2)
  );

  // APB access strobes and command decode
  always_comb begin
    bus_wr        = psel && penable && pwrite && !state.ready;
    bus_rd        = psel && penable && !pwrite && !state.ready;
    cmd_wr        = bus_wr && paddr == sequencer_pkg::OFS_COMMAND;
    cmd_go_addr   = cmd_wr && pwdata[sequencer_pkg::CMD_GO_ADDR];
    cmd_go_resume = cmd_wr && pwdata[sequencer_pkg::CMD_GO_RESUME];
    cmd_escape    = cmd_wr && pwdata[sequencer_pkg::CMD_ESCAPE];
    cmd_sw_break  = cmd_wr && pwdata[sequencer_pkg::CMD_SW_BREAK];
    cmd_ack       = halt_ack || (cmd_wr && pwdata[sequencer_pkg::CMD_HALT_ACK]);
    cmd_ind       = cmd_wr && pwdata[sequencer_pkg::CMD_EVT_IND];
  end

  // Break and freeze sources by break mode
  always_comb begin
    brk_fire = 1'b0;
    frz_fire = 1'b0;
    unique case (state.brk_mode)
      sequencer_pkg::BRK_NONE:        brk_fire = 1'b0;
      sequencer_pkg::BRK_FIRST:       brk_fire = raw_trig1;
      sequencer_pkg::BRK_SECOND:      brk_fire = raw_trig2;
      sequencer_pkg::BRK_ARM:         brk_fire = raw_trig2;
      sequencer_pkg::BRK_LIMIT:       brk_fire = raw_trig1;
      sequencer_pkg::BRK_INDEPENDENT: brk_fire = raw_trig1 || raw_trig2;
      sequencer_pkg::BRK_FREEZE: begin
        brk_fire = raw_trig2;
        frz_fire = raw_trig1;
      end
      default:                        brk_fire = 1'b0;
    endcase
    brk_fire = brk_fire && state.running;
  end

  // Counter start and stop sources
  always_comb begin
    prog_end  = cmd_escape || cmd_sw_break || halt_insn || brk_fire;
    cnt_start = arm_like ? raw_trig1 : (cmd_go_addr || cmd_go_resume);
    cnt_stop  = prog_end || (arm_like && raw_trig2);
  end

  // Next-state computation
  always_comb begin
    next_state       = state;
    next_state.trig1 = raw_trig1;
    next_state.trig2 = raw_trig2;
    next_state.ready = bus_wr || bus_rd;
    next_state.err   = 1'b0;
    // Arm alternation
    if (arm_like && raw_trig1) begin
      next_state.second_armed = 1'b1;
    end else if (arm_like && raw_trig2) begin
      next_state.second_armed = 1'b0;
    end
    // Run control
    if (cmd_go_addr || cmd_go_resume) begin
      next_state.running = 1'b1;
      next_state.frozen  = 1'b0;
    end
    if (prog_end) begin
      next_state.running = 1'b0;
    end
    if (brk_fire && state.cont) begin
      next_state.running = 1'b1;
    end
    // General purpose counter; a stop wins over a start
    if (cmd_go_addr && !arm_like) begin
      next_state.count = sequencer_pkg::COUNT_RESET;
    end else if (state.cnt_en && unit_tick && state.count < sequencer_pkg::COUNT_MAX) begin
      next_state.count = state.count + 16'h0001;
    end
    next_state.cnt_en = (state.cnt_en || cnt_start) && !cnt_stop;
    // Trace freeze; a break wins over a go that clears it
    if (brk_fire || frz_fire) begin
      next_state.frozen = 1'b1;
    end
    // Last bus transaction, so a break reports the one that fired
    if (bus_valid) begin
      next_state.last_bus  = {bus_addr, bus_data};
      next_state.last_regs = cpu_regs;
    end
    // Halt request and capture; a new break wins over an ack
    next_state.halt = (state.halt && !cmd_ack)
                   || (brk_fire && !state.cont);
    if (brk_fire) begin
      next_state.cap_addr = state.last_bus[31:16];
      next_state.cap_data = state.last_bus[15:0];
      next_state.cap_regs = state.last_regs;
    end
    // Mode register write, clear and revert
    if (bus_wr && paddr == sequencer_pkg::OFS_MODE) begin
      if (pwdata[sequencer_pkg::MODE_CLEAR_BIT]) begin
        next_state.evt_mode = sequencer_pkg::EVM_INDEPENDENT;
        next_state.brk_mode = sequencer_pkg::BRK_NONE;
        next_state.cont     = 1'b0;
      end else if (pwdata[sequencer_pkg::MODE_WRITE_BIT]) begin
        if (pwdata[sequencer_pkg::MODE_EVT_LSB +: 2] == 2'b11) begin
          next_state.err = 1'b1;
        end else begin
          next_state.evt_mode = sequencer_pkg::event_mode_t'(
            pwdata[sequencer_pkg::MODE_EVT_LSB +: 2]);
          next_state.brk_mode = sequencer_pkg::BRK_NONE;
        end
      end else begin
        if (pwdata[sequencer_pkg::MODE_BRK_LSB +: 3] == 3'b111) begin
          next_state.err = 1'b1;
        end else begin
          next_state.brk_mode = sequencer_pkg::break_mode_t'(
            pwdata[sequencer_pkg::MODE_BRK_LSB +: 3]);
          next_state.evt_mode = sequencer_pkg::EVM_INDEPENDENT;
          next_state.cont     = pwdata[sequencer_pkg::MODE_CONT_BIT];
        end
      end
      next_state.second_armed = 1'b0;
    end
    if (cmd_ind) begin
      next_state.evt_mode     = sequencer_pkg::EVM_INDEPENDENT;
      next_state.brk_mode     = sequencer_pkg::BRK_NONE;
      next_state.second_armed = 1'b0;
    end
    // Read data and unmapped address answer
    next_state.rdata = 32'h0000_0000;
    if (bus_rd || bus_wr) begin
      unique case (paddr)
        sequencer_pkg::OFS_MODE:
          next_state.rdata = {23'h000000, state.cont, 1'b0, state.brk_mode,
                              2'b00, state.evt_mode};
        sequencer_pkg::OFS_COMMAND: next_state.rdata = 32'h0000_0000;
        sequencer_pkg::OFS_STATUS:
          next_state.rdata = {27'h0000000, state.cnt_en, state.second_armed,
                              state.frozen, state.halt, state.running};
        sequencer_pkg::OFS_COUNT:   next_state.rdata = {16'h0000, state.count};
        sequencer_pkg::OFS_CAPADDR: next_state.rdata = {16'h0000, state.cap_addr};
        sequencer_pkg::OFS_CAPDATA: next_state.rdata = {16'h0000, state.cap_data};
        sequencer_pkg::OFS_CAPREG:  next_state.rdata = state.cap_regs;
        default:                    next_state.err   = 1'b1;
      endcase
      if (bus_wr) begin
        next_state.rdata = 32'h0000_0000;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= '0;
      state.evt_mode <= sequencer_pkg::EVM_INDEPENDENT;
      state.brk_mode <= sequencer_pkg::BRK_NONE;
    end else begin
      state <= next_state;
    end
  end

  assign prdata          = state.rdata;
  assign pready          = state.ready;
  assign pslverr         = state.err;
  assign first_trig_out  = state.trig1;
  assign second_trig_out = state.trig2;
  assign trace_freeze    = state.frozen;
  assign halt_request    = state.halt;
  assign run_enable      = state.running;

  // Event modes never raise a halt request
  a_event_no_break: assert property (@(posedge pclk) disable iff (!presetn)
    state.brk_mode == sequencer_pkg::BRK_NONE && !state.halt |=> !halt_request)
    else $error("halt raised in event mode");
  // Halt held until acknowledged
  a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    halt_request && !cmd_ack |=> halt_request)
    else $error("halt dropped without ack");
  // Break in step mode raises halt next cycle
  a_break_halt: assert property (@(posedge pclk) disable iff (!presetn)
    brk_fire && !state.cont |=> halt_request && trace_freeze)
    else $error("break did not halt and freeze");
  // Counter never passes its maximum
  a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
    state.count == sequencer_pkg::COUNT_MAX |=> state.count == sequencer_pkg::COUNT_MAX
      || $past(cmd_go_addr))
    else $error("counter passed saturation");
  // Arm relation: second matches only after first trigger
  a_arm_order: assert property (@(posedge pclk) disable iff (!presetn)
    arm_like && !state.second_armed |-> !match2)
    else $error("second channel matched unarmed");
  // Go with address clears the counter
  a_go_clear: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go_addr && !arm_like |=> state.count == 16'h0000 && state.cnt_en)
    else $error("go did not clear counter");
  // First trigger reaches its output one cycle later
  a_trig_out: assert property (@(posedge pclk) disable iff (!presetn)
    raw_trig1 |=> first_trig_out)
    else $error("first trigger not driven out");
  // Continue option keeps the program running
  a_continue_run: assert property (@(posedge pclk) disable iff (!presetn)
    brk_fire && state.cont && !cmd_ack |=> run_enable && !halt_request)
    else $error("continue option halted");

endmodule

/* logic/sequencer_pkg.sv */
/*
  Package for the event trigger break sequencer: register map, field
  positions, mode encodings, reset values and counter limits.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package sequencer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0C;
  localparam logic [7:0] OFS_CAPADDR = 8'h10;
  localparam logic [7:0] OFS_CAPDATA = 8'h14;
  localparam logic [7:0] OFS_CAPREG  = 8'h18;

  // Event relation encodings
  typedef enum logic [1:0] {
    EVM_INDEPENDENT  = 2'b00,
    EVM_ARM          = 2'b01,
    EVM_WINDOW_LIMIT = 2'b10
  } event_mode_t;

  // Break condition mode encodings
  typedef enum logic [2:0] {
    BRK_NONE        = 3'b000,
    BRK_FIRST       = 3'b001,
    BRK_SECOND      = 3'b010,
    BRK_ARM         = 3'b011,
    BRK_LIMIT       = 3'b100,
    BRK_INDEPENDENT = 3'b101,
    BRK_FREEZE      = 3'b110
  } break_mode_t;

  // Mode register fields
  localparam int MODE_EVT_LSB   = 0;
  localparam int MODE_BRK_LSB   = 4;
  localparam int MODE_CONT_BIT  = 8;
  localparam int MODE_WRITE_BIT = 9;
  localparam int MODE_CLEAR_BIT = 10;

  // Command register bits (write one to act)
  localparam int CMD_GO_ADDR  = 0;
  localparam int CMD_GO_RESUME = 1;
  localparam int CMD_ESCAPE   = 2;
  localparam int CMD_SW_BREAK = 3;
  localparam int CMD_HALT_ACK = 4;
  localparam int CMD_EVT_IND  = 5;

  // Status bits
  localparam int ST_RUNNING = 0;
  localparam int ST_HALT    = 1;
  localparam int ST_FROZEN  = 2;
  localparam int ST_ARMED2  = 3;
  localparam int ST_CNT_EN  = 4;

  // Counter saturation value
  localparam logic [15:0] COUNT_MAX   = 16'hFFFE;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

endpackage

/* logic/trigger_channel.sv */
/*
  One event channel's trigger stage: gated match into a pass counter and
  an optional unit delay counter, producing a one-cycle trigger.
  Assumes match, enable and counts are synchronous to pclk.
*/
`timescale 1ns/100ps
module trigger_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        match,
  input  wire logic        unit_tick,
  input  wire logic [15:0] pass_count,
  input  wire logic [15:0] delay_count,
  output logic             trigger
);

  typedef struct packed {
    logic [15:0] passes;
    logic [15:0] delay;
    logic        delaying;
    logic        trig;
  } chan_state_t;

  chan_state_t state;
  chan_state_t next_state;

  // Pass count then delay count, then one trigger pulse
  always_comb begin
    next_state      = state;
    next_state.trig = 1'b0;
    if (state.delaying) begin
      if (unit_tick) begin
        if (state.delay <= 16'h0001) begin
          next_state.delaying = 1'b0;
          next_state.trig     = 1'b1;
        end else begin
          next_state.delay = state.delay - 16'h0001;
        end
      end
    end else if (match) begin
      if (state.passes + 16'h0001 >= pass_count) begin
        next_state.passes = 16'h0000;
        if (delay_count != 16'h0000) begin
          next_state.delaying = 1'b1;
          next_state.delay    = delay_count;
        end else begin
          next_state.trig = 1'b1;
        end
      end else begin
        next_state.passes = state.passes + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign trigger = state.trig;

endmodule

/* verification/processor_side_model.sv */
/*
  Far-side model: emulator bus transactions, comparator results,
  counting units, halt-type instructions and a slow halt acknowledge.
  Assumes the bench requests one transaction per one-cycle req pulse.
*/
`timescale 1ns/100ps
module processor_side_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic [8:0]  req_match,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_data,
  input  wire logic [31:0] req_regs,
  input  wire logic        tick_all,
  input  wire logic        halt_request,
  output logic [7:0]       match,
  output logic             bus_valid,
  output logic [15:0]      bus_addr,
  output logic [15:0]      bus_data,
  output logic [31:0]      cpu_regs,
  output logic             unit_tick,
  output logic             halt_insn,
  output logic             halt_ack
);
  logic [7:0] wait_cnt;

  // Released bus lines toggle instead of holding the last value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match     <= 8'h00;
      bus_valid <= 1'b0;
      bus_addr  <= 16'h0000;
      bus_data  <= 16'h0000;
      cpu_regs  <= 32'h0000_0000;
      unit_tick <= 1'b0;
      halt_insn <= 1'b0;
      halt_ack  <= 1'b0;
      wait_cnt  <= 8'h00;
    end else begin
      bus_valid <= req & ~req_match[8];
      halt_insn <= req & req_match[8];
      match     <= req ? req_match[7:0] : ~match;
      bus_addr  <= req ? req_addr : ~bus_addr;
      bus_data  <= req ? req_data : ~bus_data;
      cpu_regs  <= req ? req_regs : cpu_regs;
      unit_tick <= tick_all | ~unit_tick;
      // Slow acknowledge, some twenty cycles after a held halt
      wait_cnt  <= (halt_request && !halt_ack) ? wait_cnt + 8'h01 : 8'h00;
      halt_ack  <= (wait_cnt == 8'h13);
    end
  end
endmodule

/* verification/tb.sv */
/*
  Bench for the event trigger break sequencer: APB register tasks,
  event relations, break modes and the general purpose counter.
  Assumes the far-side model answers transactions and acknowledges halts.
*/
`timescale 1ns/100ps
module tb;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        req = 1'b0, tick_all = 1'b0, pclk, pready, pslverr, er;
  logic        first_trig_out, second_trig_out, trace_freeze, halt_request, run_enable;
  logic        bus_valid, unit_tick, halt_insn, halt_ack;
  logic [7:0]  paddr = 8'h00, match, m;
  logic [8:0]  req_match = 9'h000;
  logic [15:0] req_addr = 16'h0000, req_data = 16'h0000, pc = 16'h0000;
  logic [15:0] bus_addr, bus_data, c1;
  logic [31:0] pwdata = 32'h0000_0000, req_regs = 32'h0000_0000, prdata, rd, cpu_regs;
  logic [1:0]  x;
  int          miscompares = 0, tests_run = 0, n1 = 0, n2 = 0, cyc = 0;

  event_trigger_break_sequencer i_event_trigger_break_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .first_addr_match(match[0]), .first_data_match(match[1]),
    .first_probe_match(match[2]), .first_cycle_match(match[3]),
    .second_addr_match(match[4]), .second_data_match(match[5]),
    .second_probe_match(match[6]), .second_cycle_match(match[7]),
    .bus_valid, .bus_addr, .bus_data, .cpu_regs, .unit_tick, .halt_insn, .halt_ack,
    .first_pass_count(pc), .first_delay_count(16'h0000),
    .second_pass_count(pc), .second_delay_count(16'h0000),
    .first_trig_out, .second_trig_out, .trace_freeze, .halt_request, .run_enable);

  processor_side_model i_processor_side_model (
    .pclk, .presetn, .req, .req_match, .req_addr, .req_data, .req_regs, .tick_all,
    .halt_request, .match, .bus_valid, .bus_addr, .bus_data, .cpu_regs, .unit_tick,
    .halt_insn, .halt_ack);

  // Clock at 25 MHz
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Trigger pulse counters and run ceiling
  always @(posedge pclk) begin
    if (first_trig_out === 1'b1) n1++;
    if (second_trig_out === 1'b1) n2++;
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic cmd(input int b);
    apb(1'b1, sequencer_pkg::OFS_COMMAND, 32'h0000_0001 << b);
  endtask

  // Select a break mode, then start with an address
  task automatic brk(input logic [2:0] b, input logic c);
    apb(1'b1, sequencer_pkg::OFS_MODE, {23'h000000, c, 1'b0, b, 4'h0});
    cmd(sequencer_pkg::CMD_GO_ADDR);
  endtask

  // One transaction; x in a count skips that channel
  task automatic ev(input logic [8:0] v, input logic e1, e2, input logic [2:0] o);
    int k;
    @(posedge pclk);
    n1 = 0;
    n2 = 0;
    req <= 1'b1;
    req_match <= v;
    req_addr <= 16'($urandom);
    req_data <= 16'($urandom);
    req_regs <= $urandom;
    @(posedge pclk);
    req <= 1'b0;
    repeat (6) @(posedge pclk);
    if (e1 !== 1'bx) chk(n1, e1);
    if (e2 !== 1'bx) chk(n2, e2);
    chk({halt_request, trace_freeze, run_enable}, o);
    for (k = 0; k < 60 && halt_request !== 1'b0; k++) @(posedge pclk);
    if (o[2]) chk(halt_request, 1'b0);
  endtask

  // Window relation needs second address and cycle too
  function automatic logic [1:0] fires(input logic [7:0] v, input logic win);
    fires = {&v[3:0] & (~win | (v[4] & v[7])), &v[7:4]};
  endfunction

  initial begin
    rd = 32'($urandom(32'hC2B175E1));
    repeat (3) @(posedge pclk);
    chk({first_trig_out, second_trig_out, trace_freeze, halt_request, run_enable}, 0);
    presetn <= 1'b1;
    rdreg(sequencer_pkg::OFS_MODE);
    chk(rd[6:0], 7'h00);
    cmd(sequencer_pkg::CMD_GO_ADDR);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0200 + 32'(2 * e));
      for (int i = 0; i < 8; i++) begin
        m = 8'($urandom | $urandom);
        m[5] = m[5] & (e == 0);
        pc <= 16'($urandom % 2);
        x = fires(m, e[0]);
        ev({1'b0, m}, x[1], x[0], 3'b001);
      end
    end
    ev(9'h09F, 1'b1, 1'b0, 3'b001);
    ev(9'h08F, 1'b0, 1'b0, 3'b001);
    // Window match counted by the first channel's pass counter
    pc <= 16'h0002;
    ev(9'h09F, 1'b0, 1'b0, 3'b001);
    ev(9'h09F, 1'b1, 1'b0, 3'b001);
    pc <= 16'h0000;
    // Arm relation, first delay count left at zero
    apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0201);
    ev(9'h0F0, 1'b0, 1'b0, 3'b001);
    ev(9'h00F, 1'b1, 1'b0, 3'b001);
    rdreg(sequencer_pkg::OFS_STATUS);
    chk(rd[4:3], 2'b11);
    ev(9'h0F0, 1'b0, 1'b1, 3'b001);
    rdreg(sequencer_pkg::OFS_COUNT);
    c1 = rd[15:0];
    rdreg(sequencer_pkg::OFS_COUNT);
    chk(rd[15:0], c1);
    chk(c1 != 16'h0000, 1'b1);
    cmd(sequencer_pkg::CMD_EVT_IND);
    rdreg(sequencer_pkg::OFS_MODE);
    chk(rd[1:0], 2'b00);
    apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0202);
    apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0400);
    rdreg(sequencer_pkg::OFS_MODE);
    chk(rd[6:0], 7'h00);
    // Counter start, stop and accumulation
    cmd(sequencer_pkg::CMD_GO_ADDR);
    cmd(sequencer_pkg::CMD_ESCAPE);
    rdreg(sequencer_pkg::OFS_STATUS);
    chk(rd[4], 1'b0);
    rdreg(sequencer_pkg::OFS_COUNT);
    c1 = rd[15:0];
    cmd(sequencer_pkg::CMD_GO_RESUME);
    ev(9'h100, 1'b0, 1'b0, 3'b000);
    rdreg(sequencer_pkg::OFS_COUNT);
    chk(rd[15:0] > c1, 1'b1);
    c1 = rd[15:0];
    cmd(sequencer_pkg::CMD_GO_ADDR);
    rdreg(sequencer_pkg::OFS_COUNT);
    chk(rd[15:0] < c1, 1'b1);
    cmd(sequencer_pkg::CMD_SW_BREAK);
    rdreg(sequencer_pkg::OFS_STATUS);
    chk({rd[4], rd[0]}, 2'b00);
    tick_all <= 1'b1;
    cmd(sequencer_pkg::CMD_GO_ADDR);
    repeat (65600) @(posedge pclk);
    rdreg(sequencer_pkg::OFS_COUNT);
    chk(rd[15:0], sequencer_pkg::COUNT_MAX);
    tick_all <= 1'b0;
    // Mode encodings, refusals and an unmapped offset
    brk(3'h3, 1'b0);
    apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0203);
    chk(er, 1'b1);
    apb(1'b1, sequencer_pkg::OFS_MODE, 32'h0000_0070);
    chk(er, 1'b1);
    rdreg(sequencer_pkg::OFS_MODE);
    chk(rd[6:0], 7'h30);
    rdreg(8'h1C);
    chk(er, 1'b1);
    ev(9'h0F0, 1'b0, 1'b0, 3'b001);
    ev(9'h00F, 1'b1, 1'b0, 3'b001);
    ev(9'h0F0, 1'b0, 1'b1, 3'b110);
    brk(3'h1, 1'b0);
    ev(9'h0F0, 1'b0, 1'bx, 3'b001);
    ev(9'h00F, 1'b1, 1'b0, 3'b110);
    rdreg(sequencer_pkg::OFS_CAPADDR);
    chk(rd[15:0], req_addr);
    rdreg(sequencer_pkg::OFS_CAPDATA);
    chk(rd[15:0], req_data);
    rdreg(sequencer_pkg::OFS_CAPREG);
    chk(rd, req_regs);
    brk(3'h2, 1'b0);
    ev(9'h00F, 1'bx, 1'b0, 3'b001);
    ev(9'h0F0, 1'b0, 1'b1, 3'b110);
    brk(3'h4, 1'b0);
    ev(9'h08F, 1'b0, 1'b0, 3'b001);
    ev(9'h09F, 1'b1, 1'b0, 3'b110);
    brk(3'h5, 1'b0);
    ev(9'h0F0, 1'b0, 1'b1, 3'b110);
    brk(3'h5, 1'b0);
    ev(9'h00F, 1'b1, 1'b0, 3'b110);
    brk(3'h6, 1'b0);
    ev(9'h00F, 1'b1, 1'b0, 3'b011);
    ev(9'h0F0, 1'b0, 1'b1, 3'b110);
    brk(3'h1, 1'b1);
    ev(9'h00F, 1'b1, 1'b0, 3'b011);
    wrap_up();
  end
endmodule
